// [src/mmio_pkg.sv]
// shared constants and types of the motor monitor parameter bank
package mmio_pkg;
  // logical addresses of the parameters
  localparam logic [15:0] ADDR_MOTOR_CURRENT = 16'h0C84;
  localparam logic [15:0] ADDR_RUN_TIME_COMM = 16'h0CAC;
  localparam logic [15:0] ADDR_RUN_TIME_DISPLAY = 16'h0CCA;
  localparam logic [15:0] ADDR_INPUT_STATES = 16'h1452;
  localparam logic [15:0] ADDR_OUTPUT_STATES = 16'h145C;
  localparam logic [15:0] ADDR_THERMAL_STATE = 16'h259E;
  localparam logic [15:0] ADDR_ENERGY_CONSUMED = 16'h299C;
  // fieldbus object index and subindex of the same parameters
  localparam logic [23:0] OBJ_MOTOR_CURRENT = 24'h200205;
  localparam logic [23:0] OBJ_RUN_TIME_COMM = 24'h20022D;
  localparam logic [23:0] OBJ_RUN_TIME_DISPLAY = 24'h20024B;
  localparam logic [23:0] OBJ_INPUT_STATES = 24'h201603;
  localparam logic [23:0] OBJ_OUTPUT_STATES = 24'h20160D;
  localparam logic [23:0] OBJ_THERMAL_STATE = 24'h20421F;
  localparam logic [23:0] OBJ_ENERGY_CONSUMED = 24'h204C35;
  // field layout of the input and output words
  localparam logic [15:0] INPUT_MASK = 16'h000F;
  localparam logic [15:0] OUTPUT_MASK = 16'h0307;
  localparam int RELAY_LSB = 0;
  localparam int DOUT_LSB = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // one-second tick at 200 MHz
  localparam int CLK_HZ = 200_000_000;
  localparam int RUN_TICK_S = 1;
  localparam int RUN_TICK_CYCLES = CLK_HZ * RUN_TICK_S;

  typedef struct packed {
    logic req;
    logic by_object;
    logic [15:0] addr;
    logic [23:0] obj;
    logic wr;
    logic [31:0] wdata;
  } mmio_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } mmio_rsp_t;

  typedef enum logic [7:0] {
    SEL_NONE = 8'h01,
    SEL_CURRENT = 8'h02,
    SEL_RT_COMM = 8'h04,
    SEL_RT_DISP = 8'h08,
    SEL_INPUTS = 8'h10,
    SEL_OUTPUTS = 8'h20,
    SEL_THERMAL = 8'h40,
    SEL_ENERGY = 8'h80
  } mmio_sel_t;
endpackage

// [src/mmio_bank.sv]
// motor monitor and digital i/o parameter bank
//
// Behaviour
// - input word holds the four digital inputs at bits 0 to 3, read only
// - output word: relays at bits 0-2, digital outputs at bits 8-9
// - written output bit takes effect only when no function drives it
// - an error clears every output that was forced by communication
// - output writes accepted only from the active command channel
// - motor current is a read-only unsigned 16-bit value
// - thermal state is a read-only 16-bit percentage, 100 is nominal
// - run time counts seconds in 32 bits, display copy writable when stopped
// - energy consumed is a read-only 32-bit kWh value
// - each parameter answers at logical address and at object index
`timescale 1ns/1ps
`default_nettype none
module mmio_bank #(
  parameter int TICK_CYCLES = mmio_pkg::RUN_TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire mmio_pkg::mmio_req_t i_req,
  input wire logic i_req_active_channel,
  output mmio_pkg::mmio_rsp_t o_rsp,
  input wire logic [15:0] i_motor_current,
  input wire logic [15:0] i_thermal_state,
  input wire logic [31:0] i_energy_consumed,
  input wire logic i_motor_energized,
  input wire logic i_motor_stopped,
  input wire logic i_error,
  input wire logic [3:0] i_digital_inputs,
  input wire logic [4:0] i_function_assigned,
  input wire logic [4:0] i_function_value,
  output logic [2:0] o_relays,
  output logic [1:0] o_digital_outputs
);
  initial begin
    if (TICK_CYCLES < 1) begin
      $error("TICK_CYCLES must be at least one");
    end
  end

  logic [31:0] tick_cnt_r;
  logic [31:0] run_time_r;
  logic [15:0] forced_r;
  logic [15:0] out_word;
  logic [15:0] assigned_word;
  logic [15:0] func_word;
  logic sec_tick;
  mmio_pkg::mmio_sel_t sel;
  mmio_pkg::mmio_rsp_t rsp_nxt;

  assign assigned_word = {6'h00, i_function_assigned[4:3], 5'h00, i_function_assigned[2:0]};
  assign func_word = {6'h00, i_function_value[4:3], 5'h00, i_function_value[2:0]};
  assign sec_tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // both address forms decode to one selector
  always_comb begin
    sel = mmio_pkg::SEL_NONE;
    if (i_req.by_object) begin
      case (i_req.obj)
        mmio_pkg::OBJ_MOTOR_CURRENT: sel = mmio_pkg::SEL_CURRENT;
        mmio_pkg::OBJ_RUN_TIME_COMM: sel = mmio_pkg::SEL_RT_COMM;
        mmio_pkg::OBJ_RUN_TIME_DISPLAY: sel = mmio_pkg::SEL_RT_DISP;
        mmio_pkg::OBJ_INPUT_STATES: sel = mmio_pkg::SEL_INPUTS;
        mmio_pkg::OBJ_OUTPUT_STATES: sel = mmio_pkg::SEL_OUTPUTS;
        mmio_pkg::OBJ_THERMAL_STATE: sel = mmio_pkg::SEL_THERMAL;
        mmio_pkg::OBJ_ENERGY_CONSUMED: sel = mmio_pkg::SEL_ENERGY;
        default: sel = mmio_pkg::SEL_NONE;
      endcase
    end else begin
      case (i_req.addr)
        mmio_pkg::ADDR_MOTOR_CURRENT: sel = mmio_pkg::SEL_CURRENT;
        mmio_pkg::ADDR_RUN_TIME_COMM: sel = mmio_pkg::SEL_RT_COMM;
        mmio_pkg::ADDR_RUN_TIME_DISPLAY: sel = mmio_pkg::SEL_RT_DISP;
        mmio_pkg::ADDR_INPUT_STATES: sel = mmio_pkg::SEL_INPUTS;
        mmio_pkg::ADDR_OUTPUT_STATES: sel = mmio_pkg::SEL_OUTPUTS;
        mmio_pkg::ADDR_THERMAL_STATE: sel = mmio_pkg::SEL_THERMAL;
        mmio_pkg::ADDR_ENERGY_CONSUMED: sel = mmio_pkg::SEL_ENERGY;
        default: sel = mmio_pkg::SEL_NONE;
      endcase
    end
  end

  // second prescaler runs only while energized, so partial seconds survive stops
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_r <= mmio_pkg::RESET_WORD;
    end else if (i_motor_energized) begin
      tick_cnt_r <= sec_tick ? mmio_pkg::RESET_WORD : tick_cnt_r + 32'h0000_0001;
    end
  end

  // single counter backs both copies; the display copy may be preset when stopped
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_time_r <= mmio_pkg::RESET_WORD;
    end else if (i_req.req && i_req.wr && sel == mmio_pkg::SEL_RT_DISP && i_motor_stopped) begin
      run_time_r <= i_req.wdata;
    end else if (i_motor_energized && sec_tick) begin
      run_time_r <= run_time_r + 32'h0000_0001;
    end
  end

  // forced output image; error wins over a write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      forced_r <= mmio_pkg::RESET_WORD[15:0];
    end else if (i_error) begin
      forced_r <= mmio_pkg::RESET_WORD[15:0];
    end else if (i_req.req && i_req.wr && sel == mmio_pkg::SEL_OUTPUTS && i_req_active_channel) begin
      forced_r <= i_req.wdata[15:0] & mmio_pkg::OUTPUT_MASK & ~assigned_word;
    end
  end

  assign out_word = ((func_word & assigned_word) | (forced_r & ~assigned_word)) & mmio_pkg::OUTPUT_MASK;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_relays <= 3'h0;
      o_digital_outputs <= 2'h0;
    end else begin
      o_relays <= out_word[mmio_pkg::RELAY_LSB +: 3];
      o_digital_outputs <= out_word[mmio_pkg::DOUT_LSB +: 2];
    end
  end

  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.ack = i_req.req;
    case (sel)
      mmio_pkg::SEL_CURRENT: rsp_nxt.rdata = {16'h0000, i_motor_current};
      mmio_pkg::SEL_THERMAL: rsp_nxt.rdata = {16'h0000, i_thermal_state};
      mmio_pkg::SEL_RT_COMM: rsp_nxt.rdata = run_time_r;
      mmio_pkg::SEL_RT_DISP: rsp_nxt.rdata = run_time_r;
      mmio_pkg::SEL_ENERGY: rsp_nxt.rdata = i_energy_consumed;
      mmio_pkg::SEL_INPUTS: rsp_nxt.rdata = {28'h0000000, i_digital_inputs};
      mmio_pkg::SEL_OUTPUTS: rsp_nxt.rdata = {16'h0000, out_word};
      default: rsp_nxt.err = i_req.req;
    endcase
    // writes to read-only words, refused channels or stopped-only while running are errors
    if (i_req.req && i_req.wr) begin
      if (sel == mmio_pkg::SEL_OUTPUTS) begin
        rsp_nxt.err = !i_req_active_channel;
      end else if (sel == mmio_pkg::SEL_RT_DISP) begin
        rsp_nxt.err = !i_motor_stopped;
      end else begin
        rsp_nxt.err = 1'b1;
      end
    end
    if (!i_req.req) begin
      rsp_nxt = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp <= '0;
    end else begin
      o_rsp <= rsp_nxt;
    end
  end
endmodule
`default_nettype wire

// [test/mmio_bank_assertions.sv]
// concurrent checks on the ports of the parameter bank
`timescale 1ns/1ps
`default_nettype none
module mmio_bank_assertions (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire mmio_pkg::mmio_req_t i_req,
  input wire logic i_req_active_channel,
  input wire mmio_pkg::mmio_rsp_t o_rsp,
  input wire logic [15:0] i_motor_current,
  input wire logic [15:0] i_thermal_state,
  input wire logic [31:0] i_energy_consumed,
  input wire logic i_error,
  input wire logic [3:0] i_digital_inputs,
  input wire logic [4:0] i_function_assigned,
  input wire logic [4:0] i_function_value,
  input wire logic [2:0] o_relays,
  input wire logic [1:0] o_digital_outputs
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic rd = i_req.req && !i_req.wr;
  wire logic wr = i_req.req && i_req.wr;
  function automatic logic at(input logic [15:0] a, input logic [23:0] o);
    return i_req.by_object ? i_req.obj == o : i_req.addr == a;
  endfunction
  a_ack_next_cycle: assert property (i_req.req |=> o_rsp.ack) else $error("request not answered");
  a_ack_has_cause: assert property (o_rsp.ack |-> $past(i_req.req)) else $error("stray answer");
  a_input_word: assert property (rd && at(mmio_pkg::ADDR_INPUT_STATES, mmio_pkg::OBJ_INPUT_STATES)
    |=> o_rsp.rdata == {28'h0, $past(i_digital_inputs)}) else $error("input word wrong");
  a_current_value: assert property (rd && at(mmio_pkg::ADDR_MOTOR_CURRENT, mmio_pkg::OBJ_MOTOR_CURRENT)
    |=> o_rsp.rdata == {16'h0, $past(i_motor_current)}) else $error("current wrong");
  a_thermal_value: assert property (rd && at(mmio_pkg::ADDR_THERMAL_STATE, mmio_pkg::OBJ_THERMAL_STATE)
    |=> o_rsp.rdata == {16'h0, $past(i_thermal_state)}) else $error("thermal wrong");
  a_energy_value: assert property (rd && at(mmio_pkg::ADDR_ENERGY_CONSUMED, mmio_pkg::OBJ_ENERGY_CONSUMED)
    |=> o_rsp.rdata == $past(i_energy_consumed)) else $error("energy wrong");
  a_ro_write_err: assert property (wr && at(mmio_pkg::ADDR_MOTOR_CURRENT, mmio_pkg::OBJ_MOTOR_CURRENT)
    |=> o_rsp.err) else $error("read-only write accepted");
  a_passive_channel: assert property (wr && !i_req_active_channel
    && at(mmio_pkg::ADDR_OUTPUT_STATES, mmio_pkg::OBJ_OUTPUT_STATES) |=> o_rsp.err) else $error("passive write taken");
  // three cycles allow for the image register and the output register
  a_error_clears: assert property (i_error [*3] |-> o_relays == (i_function_assigned[2:0] & i_function_value[2:0])
    && o_digital_outputs == (i_function_assigned[4:3] & i_function_value[4:3])) else $error("forced output kept");
  cover property (wr ##1 o_rsp.ack && !o_rsp.err);
  cover property (rd && i_req.by_object);
  cover property (i_error [*3]);
endmodule
bind mmio_bank mmio_bank_assertions mmio_bank_assertions_i (.i_sys_clk, .i_reset_n, .i_req, .i_req_active_channel,
  .o_rsp, .i_motor_current, .i_thermal_state, .i_energy_consumed, .i_error, .i_digital_inputs,
  .i_function_assigned, .i_function_value, .o_relays, .o_digital_outputs);
`default_nettype wire

// [test/mmio_master.sv]
// fieldbus master model issuing one-cycle parameter requests
`timescale 1ns/1ps
`default_nettype none
module mmio_master (
  input wire logic i_sys_clk,
  input wire mmio_pkg::mmio_rsp_t i_rsp,
  output mmio_pkg::mmio_req_t o_req,
  output logic o_active
);
  initial begin
    o_req = '0;
    o_active = 1'b1;
  end
  task automatic access(input logic b, input logic [15:0] a, input logic [23:0] o, input logic w,
      input logic [31:0] wd, input logic act, output logic [31:0] rd, output logic er, output logic to);
    int n;
    // let an edge pass so a back-to-back call never lowers and raises req in one time step
    @(posedge i_sys_clk);
    #1;
    o_req = {1'b1, b, a, o, w, wd};
    o_active = act;
    n = 0;
    @(posedge i_sys_clk);
    #1;
    // released address and write data lines are scrambled so a stale value never passes
    o_req.req = 1'b0;
    o_req.addr = ~a;
    o_req.wdata = ~wd;
    while (i_rsp.ack !== 1'b1 && n < 4) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    rd = i_rsp.rdata;
    er = i_rsp.err;
    to = (n == 4);
  endtask
endmodule
`default_nettype wire

// [test/mmio_bank_tb.sv]
// self-checking testbench of the motor monitor parameter bank
`timescale 1ns/1ps
`default_nettype none
module mmio_bank_tb;
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, act, on = 1'b0, stp = 1'b1, fault = 1'b0, er, to;
  mmio_pkg::mmio_req_t req;
  mmio_pkg::mmio_rsp_t rsp;
  logic [15:0] cur = 16'h1234, th = 16'h0064;
  logic [31:0] en = 32'h89AB_CDEF, rd;
  logic [3:0] din = 4'hA;
  logic [2:0] rel;
  logic [1:0] dq;
  int bad_count = 0, samples_checked = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  mmio_bank #(.TICK_CYCLES(4)) mmio_bank_i (.i_sys_clk, .i_reset_n, .i_req(req), .i_req_active_channel(act),
    .o_rsp(rsp), .i_motor_current(cur), .i_thermal_state(th), .i_energy_consumed(en), .i_motor_energized(on),
    .i_motor_stopped(stp), .i_error(fault), .i_digital_inputs(din), .i_function_assigned(5'h02),
    .i_function_value(5'h00), .o_relays(rel), .o_digital_outputs(dq));
  mmio_master mmio_master_i (.i_sys_clk, .i_rsp(rsp), .o_req(req), .o_active(act));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc(input logic b, input logic [15:0] a, input logic [23:0] o, input logic w,
      input logic [31:0] wd, input logic ac);
    mmio_master_i.access(b, a, o, w, wd, ac, rd, er, to);
    if (to) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  initial begin
    static logic [15:0] ad [4] = '{16'h0C84, 16'h259E, 16'h299C, 16'h1452};
    static logic [23:0] ob [4] = '{24'h200205, 24'h20421F, 24'h204C35, 24'h201603};
    static logic [31:0] ex [4] = '{32'h1234, 32'h0064, 32'h89AB_CDEF, 32'h000A};
    tick(3);
    i_reset_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      acc(i[0], ad[i/2], ob[i/2], 1'b0, 32'h0, 1'b1);
      check(rd, ex[i/2]);
    end
    acc(1'b0, 16'h0C84, 24'h0, 1'b1, 32'h1, 1'b1);
    check(er, 1'b1);
    $display("monitor reads done");
    acc(1'b0, 16'h145C, 24'h0, 1'b1, 32'hFFFF, 1'b1);
    tick(1);
    check({rel, dq}, 5'b10111);
    acc(1'b1, 16'h0, 24'h20160D, 1'b0, 32'h0, 1'b1);
    check(rd, 32'h0305);
    acc(1'b0, 16'h145C, 24'h0, 1'b1, 32'h0, 1'b0);
    tick(1);
    check({er, rel, dq}, 6'b110111);
    fault = 1'b1;
    tick(3);
    check({rel, dq}, 5'b0);
    fault = 1'b0;
    tick(2);
    check({rel, dq}, 5'b0);
    $display("output word done");
    acc(1'b0, 16'h0CCA, 24'h0, 1'b1, 32'h100, 1'b1);
    check(er, 1'b0);
    on = 1'b1;
    tick(20);
    on = 1'b0;
    acc(1'b0, 16'h0CAC, 24'h0, 1'b0, 32'h0, 1'b1);
    // prescaler starts at zero and 20 energized edges make five whole seconds
    check(rd, 32'h105);
    stp = 1'b0;
    acc(1'b0, 16'h0CCA, 24'h0, 1'b1, 32'h0, 1'b1);
    check(er, 1'b1);
    $display("run time done");
    print_verdict();
  end
endmodule
`default_nettype wire
